// File: rtl/url_map.svh
`ifndef URL_MAP_SVH
`define URL_MAP_SVH

// ----------------------------------------
// Register addresses (A2..A0)
// ----------------------------------------
`define URL_A_DATA      3'h0
`define URL_A_IER       3'h1
`define URL_A_ISR       3'h2
`define URL_A_LCR       3'h3
`define URL_A_MCR       3'h4
`define URL_A_LSR       3'h5
`define URL_A_MSR       3'h6
`define URL_A_SPR       3'h7

// ----------------------------------------
// Field positions and key values
// ----------------------------------------
`define URL_LCR_ENH     8'hbf
`define URL_LCR_DLAB    7
`define URL_MCR_LOOP    4
`define URL_MCR_OP2     3
`define URL_MCR_OP1     2
`define URL_MCR_RTS     1
`define URL_MCR_DTR     0
`define URL_EFR_ENH     4
`define URL_EFR_ACTS    7
`define URL_EFR_ARTS    6
`define URL_FEATURE_CONTROL_REG_LVL    6
`define URL_DIV_ZERO    8'h00

// ----------------------------------------
// Enhanced bit masks
// ----------------------------------------
`define URL_IER_ENH_MSK 8'hf0
`define URL_FCR_ENH_MSK 8'h30
`define URL_MCR_ENH_MSK 8'he0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define URL_REG_RST     8'h00

`endif

// File: rtl/url_pkg.sv
`default_nettype none

package url_pkg;

    typedef struct packed {
        logic       cs_n;
        logic       channel_select_pin;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } url_bus_type;

    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } url_modem_type;

    typedef struct packed {
        logic [7:0] dll;
        logic [7:0] divisor_high_reg;
        logic [7:0] alternate_function_reg;
        logic [7:0] divisor_fraction_reg;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] fifo_control_reg;
        logic [7:0] line_control_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] scratch_pad_reg;
        logic [7:0] enhanced_mode_select_reg;
        logic [7:0] trigger_level_reg;
        logic [7:0] feature_control_reg;
        logic [7:0] enhanced_function_reg;
        logic [7:0] xon1;
        logic [7:0] xon2;
        logic [7:0] xoff1;
        logic [7:0] xoff2;
    } url_cfg_type;

    typedef struct packed {
        logic thr_wr;
        logic fcr_wr;
        logic trg_wr;
        logic enhanced_mode_select_reg_wr;
        logic rhr_rd;
        logic isr_rd;
        logic lsr_rd;
        logic msr_rd;
    } url_ev_type;

    typedef struct packed {
        url_bus_type   bus1;
        url_bus_type   bus2;
        url_bus_type   bus3;
        logic          rx1;
        logic          rx2;
        url_modem_type mdm1;
        url_modem_type mdm2;
        url_cfg_type   cfg;
        url_ev_type    ev;
        logic [7:0]    wdata;
        logic [7:0]    rdata;
        logic          oe;
        logic          tx_pin;
        logic          rts_n;
        logic          dtr_n;
        logic          rx_core;
        url_modem_type mdm_core;
        logic          auto_cts;
        logic          auto_rts;
    } url_st_type;

endpackage

`default_nettype wire

// File: rtl/url_regsel.sv
// Summary of operation
// [RQ1] Modem control bit 4 set enters loopback; clearing it leaves loopback.
// [RQ2] In loopback the transmit serial stream feeds the receive shifter.
// [RQ3] In loopback the TX, RTS and DTR pins are held high.
// [RQ4] In loopback external CTS, DSR, CD and RI pins are ignored.
// [RQ5] All other channel functions keep working in loopback.
// [RQ6] Automatic RTS/CTS flow control is switched off in loopback.
// [RQ7] Host keeps RX pin high during loopback or a false break appears.
// [RQ8] Each channel has own registers, picked by chip select and channel pin.
// [RQ9] Address 0, divisor bit clear: read receive data, write transmit data.
// [RQ10] Divisor bit set, not 0xBF: addresses 0 and 1 hold divisor bytes.
// [RQ11] Divisor bit set, not 0xBF: address 2 is alternate or fractional.
// [RQ12] Zero divisor with divisor bit set reads revision and ident codes.
// [RQ13] Divisor bit clear: address 1 is the interrupt enable register.
// [RQ14] Normal mode address 2: read interrupt status, write FIFO control.
// [RQ15] Address 3 is always line control; address 4 normally modem control.
// [RQ16] Normal mode: address 5 reads line status, address 6 modem status.
// [RQ17] Normal mode, feature bit 6 clear: address 7 is scratch pad.
// [RQ18] Feature bit 6 set: address 7 reads level, writes mode select.
// [RQ19] Line control 0xBF: address 0 trigger/count, 1 feature, 2 enhanced.
// [RQ20] Line control 0xBF: addresses 4 to 7 hold resume and stop characters.
// [RQ21] Enhanced bits are writable only while enhanced bit 4 is set.
// [RQ22] Registers are 8 bits; decoding uses current control registers.
`default_nettype none
`include "url_map.svh"

module url_regsel #(
    parameter logic       CHANNEL  = 1'b0,
    parameter logic [7:0] REV_CODE = 8'h01,  // Arbitrary value
    parameter logic [7:0] ID_CODE  = 8'h5a   // Arbitrary value
) (
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    input  wire url_pkg::url_bus_type   bus_i,
    output logic [7:0]                  data_o,
    output logic                        data_oe_o,
    input  wire logic [7:0]             rhr_data_i,
    input  wire logic [7:0]             isr_i,
    input  wire logic [7:0]             lsr_i,
    input  wire logic [7:0]             msr_i,
    input  wire logic [7:0]             fifo_count_i,
    input  wire logic [7:0]             fifo_level_i,
    input  wire logic                   tx_serial_i,
    input  wire logic                   rx_pin_i,
    input  wire url_pkg::url_modem_type modem_pin_i,
    output url_pkg::url_cfg_type        cfg_o,
    output url_pkg::url_ev_type         ev_o,
    output logic [7:0]                  wdata_o,
    output logic                        tx_pin_o,
    output logic                        rts_n_o,
    output logic                        dtr_n_o,
    output logic                        rx_serial_o,
    output url_pkg::url_modem_type      modem_o,
    output logic                        auto_cts_en_o,
    output logic                        auto_rts_en_o
);

    url_pkg::url_st_type s_q;
    url_pkg::url_st_type s_d;

    // ----------------------------------------
    // Enhanced bit write guard
    // ----------------------------------------
    function automatic logic [7:0] guard(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] msk,
                                         input logic       en);
        guard = en ? new_v : ((new_v & ~msk) | (old_v & msk));
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic       rd_go;
        logic       wr_go;
        logic       enh;
        logic       dlab;
        logic       efr_en;
        logic       div0;
        logic       loop;
        logic [2:0] ra;
        logic [2:0] wa;
        logic [7:0] wd;
        logic [7:0] rv;
        rd_go  = 1'b0;
        wr_go  = 1'b0;
        enh    = 1'b0;
        dlab   = 1'b0;
        efr_en = 1'b0;
        div0   = 1'b0;
        loop   = 1'b0;
        ra     = 3'h0;
        wa     = 3'h0;
        wd     = 8'h00;
        rv     = 8'h00;
        s_d    = s_q;
        s_d.bus1 = bus_i;
        s_d.bus2 = s_q.bus1;
        s_d.bus3 = s_q.bus2;
        s_d.rx1  = rx_pin_i;
        s_d.rx2  = s_q.rx1;
        s_d.mdm1 = modem_pin_i;
        s_d.mdm2 = s_q.mdm1;
        s_d.ev   = '0;

        // Channel selection and strobe edges
        rd_go = !s_q.bus2.cs_n && (s_q.bus2.channel_select_pin == CHANNEL) &&
                !s_q.bus2.rd_n && s_q.bus3.rd_n; // RQ8
        wr_go = !s_q.bus3.cs_n && (s_q.bus3.channel_select_pin == CHANNEL) &&
                s_q.bus2.wr_n && !s_q.bus3.wr_n; // RQ8
        s_d.oe = !s_q.bus2.cs_n && (s_q.bus2.channel_select_pin == CHANNEL) &&
                 !s_q.bus2.rd_n;
        ra = s_q.bus2.addr;
        wa = s_q.bus3.addr;
        wd = s_q.bus3.data;

        // Decode from live control registers
        enh    = (s_q.cfg.line_control_reg == `URL_LCR_ENH); // RQ22
        dlab   = s_q.cfg.line_control_reg[`URL_LCR_DLAB];
        efr_en = s_q.cfg.enhanced_function_reg[`URL_EFR_ENH];
        div0   = (s_q.cfg.dll == `URL_DIV_ZERO) &&
                 (s_q.cfg.divisor_high_reg == `URL_DIV_ZERO);

        // ----------------------------------------
        // Read path
        // ----------------------------------------
        case (ra)
            `URL_A_DATA: begin
                if (enh) begin
                    rv = fifo_count_i; // RQ19
                end else if (dlab) begin
                    rv = div0 ? REV_CODE : s_q.cfg.dll; // RQ10 RQ12
                end else begin
                    rv = rhr_data_i; // RQ9
                    s_d.ev.rhr_rd = rd_go;
                end
            end
            `URL_A_IER: begin
                if (enh) begin
                    rv = s_q.cfg.feature_control_reg; // RQ19
                end else if (dlab) begin
                    rv = div0 ? ID_CODE : s_q.cfg.divisor_high_reg; // RQ10 RQ12
                end else begin
                    rv = s_q.cfg.interrupt_enable_reg; // RQ13
                end
            end
            `URL_A_ISR: begin
                if (enh) begin
                    rv = s_q.cfg.enhanced_function_reg; // RQ19
                end else if (dlab) begin
                    rv = efr_en ? s_q.cfg.divisor_fraction_reg : s_q.cfg.alternate_function_reg; // RQ11
                end else begin
                    rv = isr_i; // RQ14
                    s_d.ev.isr_rd = rd_go;
                end
            end
            `URL_A_LCR: rv = s_q.cfg.line_control_reg; // RQ15
            `URL_A_MCR: rv = enh ? s_q.cfg.xon1 : s_q.cfg.modem_control_reg; // RQ15 RQ20
            `URL_A_LSR: begin
                rv = enh ? s_q.cfg.xon2 : lsr_i; // RQ16 RQ20
                s_d.ev.lsr_rd = rd_go && !enh;
            end
            `URL_A_MSR: begin
                rv = enh ? s_q.cfg.xoff1 : msr_i; // RQ16 RQ20
                s_d.ev.msr_rd = rd_go && !enh;
            end
            default: begin
                if (enh) begin
                    rv = s_q.cfg.xoff2; // RQ20
                end else if (s_q.cfg.feature_control_reg[`URL_FEATURE_CONTROL_REG_LVL]) begin
                    rv = fifo_level_i; // RQ18
                end else begin
                    rv = s_q.cfg.scratch_pad_reg; // RQ17
                end
            end
        endcase
        if (rd_go) begin
            s_d.rdata = rv;
        end else begin
            s_d.ev.rhr_rd = 1'b0;
            s_d.ev.isr_rd = 1'b0;
        end

        // ----------------------------------------
        // Write path
        // ----------------------------------------
        if (wr_go) begin
            s_d.wdata = wd;
            case (wa)
                `URL_A_DATA: begin
                    if (enh) begin
                        s_d.cfg.trigger_level_reg = wd; // RQ19
                        s_d.ev.trg_wr = 1'b1;
                    end else if (dlab) begin
                        s_d.cfg.dll = wd; // RQ10
                    end else begin
                        s_d.ev.thr_wr = 1'b1; // RQ9
                    end
                end
                `URL_A_IER: begin
                    if (enh) begin
                        s_d.cfg.feature_control_reg = wd; // RQ19
                    end else if (dlab) begin
                        s_d.cfg.divisor_high_reg = wd; // RQ10
                    end else begin
                        s_d.cfg.interrupt_enable_reg = guard(s_q.cfg.interrupt_enable_reg, wd,
                            `URL_IER_ENH_MSK, efr_en); // RQ13 RQ21
                    end
                end
                `URL_A_ISR: begin
                    if (enh) begin
                        s_d.cfg.enhanced_function_reg = wd; // RQ19
                    end else if (dlab && efr_en) begin
                        s_d.cfg.divisor_fraction_reg = wd; // RQ11
                    end else if (dlab) begin
                        s_d.cfg.alternate_function_reg = wd; // RQ11
                    end else begin
                        s_d.cfg.fifo_control_reg = guard(s_q.cfg.fifo_control_reg, wd,
                            `URL_FCR_ENH_MSK, efr_en); // RQ14 RQ21
                        s_d.ev.fcr_wr = 1'b1;
                    end
                end
                `URL_A_LCR: s_d.cfg.line_control_reg = wd; // RQ15
                `URL_A_MCR: begin
                    if (enh) begin
                        s_d.cfg.xon1 = wd; // RQ20
                    end else begin
                        s_d.cfg.modem_control_reg = guard(s_q.cfg.modem_control_reg, wd,
                            `URL_MCR_ENH_MSK, efr_en); // RQ15 RQ21
                    end
                end
                `URL_A_LSR: begin
                    if (enh) begin
                        s_d.cfg.xon2 = wd; // RQ20
                    end
                end
                `URL_A_MSR: begin
                    if (enh) begin
                        s_d.cfg.xoff1 = wd; // RQ20
                    end
                end
                default: begin
                    if (enh) begin
                        s_d.cfg.xoff2 = wd; // RQ20
                    end else if (s_q.cfg.feature_control_reg[`URL_FEATURE_CONTROL_REG_LVL]) begin
                        s_d.cfg.enhanced_mode_select_reg = wd; // RQ18
                        s_d.ev.enhanced_mode_select_reg_wr = 1'b1;
                    end else begin
                        s_d.cfg.scratch_pad_reg = wd; // RQ17
                    end
                end
            endcase
        end

        // ----------------------------------------
        // Loopback routing
        // ----------------------------------------
        loop = s_q.cfg.modem_control_reg[`URL_MCR_LOOP]; // RQ1
        s_d.tx_pin  = loop ? 1'b1 : tx_serial_i; // RQ3
        s_d.rts_n   = loop ? 1'b1 : !s_q.cfg.modem_control_reg[`URL_MCR_RTS]; // RQ3
        s_d.dtr_n   = loop ? 1'b1 : !s_q.cfg.modem_control_reg[`URL_MCR_DTR]; // RQ3
        s_d.rx_core = loop ? tx_serial_i : s_q.rx2; // RQ2 RQ5
        if (loop) begin
            s_d.mdm_core.cts_n = !s_q.cfg.modem_control_reg[`URL_MCR_RTS]; // RQ4
            s_d.mdm_core.dsr_n = !s_q.cfg.modem_control_reg[`URL_MCR_DTR]; // RQ4
            s_d.mdm_core.cd_n  = !s_q.cfg.modem_control_reg[`URL_MCR_OP2]; // RQ4
            s_d.mdm_core.ri_n  = !s_q.cfg.modem_control_reg[`URL_MCR_OP1]; // RQ4
        end else begin
            s_d.mdm_core = s_q.mdm2; // RQ5
        end
        s_d.auto_cts = s_q.cfg.enhanced_function_reg[`URL_EFR_ACTS] && !loop; // RQ6
        s_d.auto_rts = s_q.cfg.enhanced_function_reg[`URL_EFR_ARTS] && !loop; // RQ6
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.bus1     <= '1;
            s_q.bus2     <= '1;
            s_q.bus3     <= '1;
            s_q.rx1      <= 1'b1;
            s_q.rx2      <= 1'b1;
            s_q.mdm1     <= '1;
            s_q.mdm2     <= '1;
            s_q.cfg      <= {17{`URL_REG_RST}};
            s_q.tx_pin   <= 1'b1;
            s_q.rts_n    <= 1'b1;
            s_q.dtr_n    <= 1'b1;
            s_q.rx_core  <= 1'b1;
            s_q.mdm_core <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign data_o        = s_q.rdata;
    assign data_oe_o     = s_q.oe;
    assign cfg_o         = s_q.cfg;
    assign ev_o          = s_q.ev;
    assign wdata_o       = s_q.wdata;
    assign tx_pin_o      = s_q.tx_pin;
    assign rts_n_o       = s_q.rts_n;
    assign dtr_n_o       = s_q.dtr_n;
    assign rx_serial_o   = s_q.rx_core;
    assign modem_o       = s_q.mdm_core;
    assign auto_cts_en_o = s_q.auto_cts;
    assign auto_rts_en_o = s_q.auto_rts;

endmodule

`default_nettype wire

// File: sim/url_properties.sv
`default_nettype none

// ----
// Checker
// ----
module url_properties #(
    parameter logic CHANNEL = 1'b0
) (
    input wire logic                   clock_i,
    input wire logic                   rst_i,
    input wire url_pkg::url_bus_type   bus_i,
    input wire logic [7:0]             data_o,
    input wire logic                   data_oe_o,
    input wire logic [7:0]             rhr_data_i,
    input wire logic [7:0]             isr_i,
    input wire logic                   tx_serial_i,
    input wire url_pkg::url_cfg_type   cfg_o,
    input wire url_pkg::url_ev_type    ev_o,
    input wire logic [7:0]             wdata_o,
    input wire logic                   tx_pin_o,
    input wire logic                   rts_n_o,
    input wire logic                   dtr_n_o,
    input wire logic                   rx_serial_o,
    input wire url_pkg::url_modem_type modem_o,
    input wire logic                   auto_cts_en_o,
    input wire logic                   auto_rts_en_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence loop_s;
        (cfg_o.modem_control_reg[4] && $stable(cfg_o.modem_control_reg))[*3];
    endsequence
    sequence norm_s;
        (!cfg_o.modem_control_reg[4] && $stable(cfg_o.modem_control_reg))[*3];
    endsequence

    a_loop_pins: assert property (
        loop_s |-> tx_pin_o && rts_n_o && dtr_n_o)
        else $error("pins not held in loopback");
    a_loop_path: assert property (
        loop_s |-> rx_serial_o == $past(tx_serial_i))
        else $error("loopback path broken");
    a_loop_modem: assert property (loop_s |-> modem_o ==
        {!cfg_o.modem_control_reg[1], !cfg_o.modem_control_reg[0], !cfg_o.modem_control_reg[3], !cfg_o.modem_control_reg[2]})
        else $error("modem inputs not ignored in loopback");
    a_loop_auto: assert property (
        loop_s |-> !auto_cts_en_o && !auto_rts_en_o)
        else $error("auto flow control active in loopback");
    a_norm_pins: assert property (norm_s |-> rts_n_o == !cfg_o.modem_control_reg[1]
        && dtr_n_o == !cfg_o.modem_control_reg[0] && tx_pin_o == $past(tx_serial_i))
        else $error("pins wrong outside loopback");
    a_rhr_read: assert property (
        ev_o.rhr_rd |-> data_o == $past(rhr_data_i))
        else $error("receive data read wrong");
    a_isr_read: assert property (
        ev_o.isr_rd |-> data_o == $past(isr_i))
        else $error("status read wrong");
    a_thr_strobe: assert property (ev_o.thr_wr |->
        wdata_o == bus_i.data ##1 !ev_o.thr_wr)
        else $error("transmit write strobe wrong");
    a_no_write: assert property ((bus_i.wr_n || bus_i.cs_n
        || bus_i.channel_select_pin != CHANNEL)[*8] |-> $stable(cfg_o))
        else $error("registers changed without write");
    a_oe_idle: assert property ((bus_i.rd_n || bus_i.cs_n
        || bus_i.channel_select_pin != CHANNEL)[*5] |-> !data_oe_o)
        else $error("data enabled without read");
    a_enh_mask: assert property (!cfg_o.enhanced_function_reg[4] |=>
        $stable(cfg_o.modem_control_reg[7:5]) && $stable(cfg_o.interrupt_enable_reg[7:4]))
        else $error("enhanced bits changed");

    c_loop: cover property (loop_s);
    c_enh: cover property (cfg_o.line_control_reg == 8'hbf && ev_o.trg_wr);
    c_read: cover property (ev_o.rhr_rd);
endmodule

bind url_regsel url_properties #(.CHANNEL(CHANNEL)) u_url_properties (
    .clock_i, .rst_i, .bus_i, .data_o, .data_oe_o, .rhr_data_i, .isr_i,
    .tx_serial_i, .cfg_o, .ev_o, .wdata_o, .tx_pin_o, .rts_n_o, .dtr_n_o,
    .rx_serial_o, .modem_o, .auto_cts_en_o, .auto_rts_en_o
);

`default_nettype wire

// File: sim/url_host.sv
`default_nettype none

// ----
// Host bus model
// ----
module url_host (
    input  wire logic                clock_i,
    input  wire logic [7:0]          data_i,
    output var url_pkg::url_bus_type bus_o,
    output var logic                 rx_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_o = '{1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 8'h00};
        rx_o = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic wr(input logic ch, input logic [2:0] a,
                      input logic [7:0] d);
        hold(1);
        bus_o.cs_n = 1'b0;
        bus_o.channel_select_pin = ch;
        bus_o.addr = a;
        bus_o.data = d;
        hold(1);
        bus_o.wr_n = 1'b0;
        hold(4);
        bus_o.wr_n = 1'b1;
        hold(4);
        bus_o.cs_n = 1'b1;
        bus_o.data = ~d;
    endtask

    task automatic rd(input logic ch, input logic [2:0] a,
                      output logic [7:0] d);
        hold(1);
        bus_o.cs_n = 1'b0;
        bus_o.channel_select_pin = ch;
        bus_o.addr = a;
        hold(1);
        bus_o.rd_n = 1'b0;
        hold(5);
        d = data_i;
        bus_o.rd_n = 1'b1;
        hold(4);
        bus_o.cs_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// File: sim/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic       CH  = 1'b1;
    localparam logic [7:0] REV = 8'hc4;  // Arbitrary value
    localparam logic [7:0] ID  = 8'h3b;  // Arbitrary value

    logic                   clock_i, rst_i, tx_s, rxp;
    logic                   txp, rtsn, dtrn, rxs, acts, arts, oe;
    logic                   oe_hit = 1'b0;
    logic [7:0]             evseen = 8'h00;
    logic [7:0]             base, dout, wd, v;
    url_pkg::url_bus_type   bus;
    url_pkg::url_modem_type mdm, mdm_o;
    url_pkg::url_cfg_type   cfg;
    url_pkg::url_ev_type    ev;
    int                     failures = 0;
    int                     checks_done = 0;
    int                     nthr = 0;

    url_regsel #(.CHANNEL(CH), .REV_CODE(REV), .ID_CODE(ID)) u_url_regsel (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .bus_i        (bus),
        .data_o       (dout),
        .data_oe_o    (oe),
        .rhr_data_i   (base),
        .isr_i        (base + 8'h01),
        .lsr_i        (base + 8'h02),
        .msr_i        (base + 8'h03),
        .fifo_count_i (base + 8'h04),
        .fifo_level_i (base + 8'h05),
        .tx_serial_i  (tx_s),
        .rx_pin_i     (rxp),
        .modem_pin_i  (mdm),
        .cfg_o        (cfg),
        .ev_o         (ev),
        .wdata_o      (wd),
        .tx_pin_o     (txp),
        .rts_n_o      (rtsn),
        .dtr_n_o      (dtrn),
        .rx_serial_o  (rxs),
        .modem_o      (mdm_o),
        .auto_cts_en_o(acts),
        .auto_rts_en_o(arts)
    );

    url_host u_url_host (
        .clock_i(clock_i),
        .data_i (dout),
        .bus_o  (bus),
        .rx_o   (rxp)
    );

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        if (ev.thr_wr === 1'b1) nthr++;
        if (!rst_i) evseen <= evseen | ev;
        if (oe === 1'b1) oe_hit <= 1'b1;
    end

    // ----
    // Helpers
    // ----
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        oe_hit = 1'b0;
        u_url_host.rd(CH, a, v);
        chk(v, exp);
        chk({7'h0, oe_hit}, 8'h01);
        chk({7'h0, oe}, 8'h00);
    endtask

    task automatic w(input logic [2:0] a, input logic [7:0] d);
        u_url_host.wr(CH, a, d);
    endtask

    initial begin
        #60us;
        failures++;
        end_of_test();
    end

    // ----
    // Tests
    // ----
    initial begin
        rst_i = 1'b1;
        tx_s = 1'b1;
        mdm = 4'hf;
        base = 8'h30;
        repeat (20) @(negedge clock_i);
        rst_i = 1'b0;
        rc(3'h3, 8'h00);
        rc(3'h0, 8'h30);
        base = 8'ha0;
        rc(3'h0, 8'ha0);
        rc(3'h2, 8'ha1);
        rc(3'h5, 8'ha2);
        rc(3'h6, 8'ha3);
        w(3'h0, 8'h5c);
        chk(wd, 8'h5c);
        chk(8'(nthr), 8'h01);
        w(3'h2, 8'hff);
        chk(cfg.fifo_control_reg, 8'hcf);
        w(3'h1, 8'hff);
        rc(3'h1, 8'h0f);
        w(3'h4, 8'he3);
        rc(3'h4, 8'h03);
        w(3'h7, 8'h9d);
        rc(3'h7, 8'h9d);
        u_url_host.wr(~CH, 3'h7, 8'h42);
        oe_hit = 1'b0;
        u_url_host.rd(~CH, 3'h7, v);
        chk(v, 8'h9d);
        chk({7'h0, oe_hit}, 8'h00);
        rc(3'h7, 8'h9d);
        w(3'h5, 8'h77);
        rc(3'h5, 8'ha2);
        w(3'h3, 8'h80);
        rc(3'h0, REV);
        rc(3'h1, ID);
        w(3'h2, 8'h66);
        rc(3'h2, 8'h66);
        w(3'h0, 8'h12);
        w(3'h1, 8'h34);
        rc(3'h0, 8'h12);
        rc(3'h1, 8'h34);
        w(3'h3, 8'hbf);
        rc(3'h3, 8'hbf);
        rc(3'h0, 8'ha4);
        w(3'h0, 8'h21);
        chk(cfg.trigger_level_reg, 8'h21);
        w(3'h1, 8'h40);
        rc(3'h1, 8'h40);
        w(3'h2, 8'hd0);
        rc(3'h2, 8'hd0);
        for (int i = 4; i < 8; i++) w(3'(i), 8'(8'h50 + i));
        for (int i = 4; i < 8; i++) rc(3'(i), 8'(8'h50 + i));
        chk(cfg.xon1, 8'h54);
        chk(cfg.xoff2, 8'h57);
        w(3'h3, 8'h80);
        w(3'h2, 8'h55);
        chk(cfg.divisor_fraction_reg, 8'h55);
        chk(cfg.alternate_function_reg, 8'h66);
        w(3'h3, 8'h03);
        rc(3'h7, 8'ha5);
        w(3'h7, 8'h3c);
        chk(cfg.enhanced_mode_select_reg, 8'h3c);
        chk(cfg.scratch_pad_reg, 8'h9d);
        w(3'h1, 8'hff);
        rc(3'h1, 8'hff);
        mdm = 4'h0;
        w(3'h4, 8'h12);
        rc(3'h4, 8'h12);
        chk({3'h0, txp, rtsn, dtrn, acts, arts}, 8'h1c);
        chk({4'h0, mdm_o}, 8'h07);
        tx_s = 1'b0;
        repeat (2) @(negedge clock_i);
        chk({7'h0, rxs}, 8'h00);
        tx_s = 1'b1;
        repeat (2) @(negedge clock_i);
        chk({7'h0, rxs}, 8'h01);
        rc(3'h2, 8'ha1);
        w(3'h4, 8'h03);
        rc(3'h4, 8'h03);
        chk({3'h0, txp, rtsn, dtrn, acts, arts}, 8'h13);
        chk({4'h0, mdm_o}, 8'h00);
        chk(evseen, 8'hff);
        chk(8'(nthr), 8'h01);
        end_of_test();
    end
endmodule

`default_nettype wire
